/* File: hdl/msc_top.sv */
/*
  Serial control of an eight-channel successive approximation converter:
  configuration word in, previous result out, conversion start and busy,
  plus an Avalon-MM register slave for status, last result and step time.
  Assumes serial clock, serial input, read enable, conversion start and
  comparator arrive asynchronously and are slower than sys_clk_i / 4.
*/
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
// Notes on behaviour
// - Serial input ignored while read enable high
// - Serial output driven only with read enable low
// - Conversion starts on conversion-start rising edge
// - Eight rising edges capture configuration word
// - Acquire from sixth-bit falling edge until start
// - Start edges ignored while converting
// - Bits resolved top first by approximation
// - Finished result loads the output shift register
// - Result width twelve, fourteen or sixteen bits
// - Unipolar results are straight binary
// - Bipolar results are two's complement
// - Configuration sets channel and range together
// - Single-ended or differential per conversion
// - Busy low throughout each conversion
// - Shift out on falling, sample on rising
// - Readout belongs to previous configuration
// - Narrow variants pad trailing zero bits
`timescale 1ns/10ps
`default_nettype none
module msc_top #(
  parameter int unsigned RES_BITS = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic rd_n_i,
  input wire logic convert_start_i,
  input wire logic cmp_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic busy_n_o,
  output logic [msc_pkg::RESULT_W-1:0] dac_code_o,
  output logic [3:0] mux_cfg_o,
  output logic single_ended_o,
  output logic unipolar_select_o,
  output logic gain_o,
  output logic nap_o,
  output logic sleep_o,
  output logic acquire_o
);
  import msc_pkg::*;

  // Pin synchronisers, two stages each
  logic [4:0] sync1_reg; // First stage, read only by second
  logic [4:0] sync2_reg; // Second stage
  logic sclk_d_reg; // Delayed serial clock for edges
  logic conv_d_reg; // Delayed start for edges

  // Serial side state
  logic [3:0] bit_cnt_reg; // Rising edges taken since the last conversion start
  logic [7:0] cfg_shift_reg; // Incoming configuration bits
  logic [7:0] cfg_reg; // Last full configuration word
  logic [7:0] cfg_conv_reg; // Configuration of running conversion
  logic [RESULT_W-1:0] out_shift_reg; // Result being shifted out
  logic out_bit_reg; // Serial output flop
  logic acq_reg; // Acquisition window open
  logic [7:0] acq_cnt_reg; // Acquisition time elapsed, saturating
  logic acq_ok_reg; // Last start met the settling time

  // Register file
  logic [7:0] step_reg; // Cycles per bit decision
  logic [RESULT_W-1:0] result_reg; // Last formatted result
  logic [15:0] conv_cnt_reg; // Finished conversions
  logic ack_reg; // Bus answer phase
  logic [31:0] rdata_reg; // Read data flop

  // Converter engine
  logic sar_busy;
  logic sar_done;
  logic [RES_BITS-1:0] sar_result;
  logic [RES_BITS-1:0] sar_code;

  // Synchronised pins
  wire logic sclk_s = sync2_reg[0];
  wire logic sin_s = sync2_reg[1];
  wire logic rd_n_s = sync2_reg[2];
  wire logic conv_s = sync2_reg[3];
  wire logic cmp_s = sync2_reg[4];

  // Edge decode
  wire logic sclk_rise = sclk_s & ~sclk_d_reg;
  wire logic sclk_fall = ~sclk_s & sclk_d_reg;
  wire logic conv_rise = conv_s & ~conv_d_reg;
  // Sampling only while read enable is low
  wire logic take_bit = sclk_rise & ~rd_n_s & (bit_cnt_reg < 4'(CFG_W));
  wire logic last_bit = take_bit & (bit_cnt_reg == 4'(CFG_W - 1));
  // Shift out on falling edges while enabled
  wire logic shift_out = sclk_fall & ~rd_n_s;
  wire logic acq_open = sclk_fall & ~rd_n_s & (bit_cnt_reg == ACQ_OPEN_BIT);
  // A start edge during a conversion is dropped
  wire logic start_conv = conv_rise & ~sar_busy;
  wire logic [7:0] cfg_full = {cfg_shift_reg[6:0], sin_s};
  wire logic acq_met = (acq_cnt_reg == 8'(ACQ_MIN_CYC));

  // Result formatting: top bit flipped for bipolar, padded low bits
  wire logic bipolar = ~cfg_conv_reg[CFG_UNIPOLAR_BIT];
  wire logic [RES_BITS-1:0] coded = {sar_result[RES_BITS-1] ^ bipolar,
    sar_result[RES_BITS-2:0]};
  wire logic [RESULT_W-1:0] padded = RESULT_W'(coded) << (RESULT_W - RES_BITS);

  // Bus decode
  wire logic req = avs_read_i | avs_write_i;
  wire logic sel_status = (avs_address_i == REG_STATUS_OFS);
  wire logic sel_result = (avs_address_i == REG_RESULT_OFS);
  wire logic sel_ctrl = (avs_address_i == REG_CTRL_OFS);
  wire logic ctrl_wr = avs_write_i & ack_reg & sel_ctrl;
  wire logic [31:0] status_word = {conv_cnt_reg, cfg_reg, 5'h00, acq_ok_reg, acq_reg, sar_busy};
  wire logic [31:0] read_mux = sel_status ? status_word :
    sel_result ? {16'h0000, result_reg} :
    sel_ctrl ? {24'h00_0000, step_reg} : 32'h0000_0000;

  msc_sar #(
    .W(RES_BITS)
  ) u_sar (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start_conv),
    .step_i(step_reg),
    .cmp_i(cmp_s),
    .code_o(sar_code),
    .busy_o(sar_busy),
    .done_o(sar_done),
    .result_o(sar_result)
  );

  // Two-stage synchronisers and edge history
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 5'h04;
      sync2_reg <= 5'h04;
      sclk_d_reg <= 1'b0;
      conv_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {cmp_i, convert_start_i, rd_n_i, serial_in_i, sclk_i};
      sync2_reg <= sync1_reg;
      sclk_d_reg <= sclk_s;
      conv_d_reg <= conv_s;
    end
  end

  // Configuration capture, count restarts with each conversion
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= 4'h0;
      cfg_shift_reg <= CFG_RST;
      cfg_reg <= CFG_RST;
    end else if (start_conv) begin
      bit_cnt_reg <= 4'h0;
    end else if (take_bit) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      cfg_shift_reg <= cfg_full;
      if (last_bit) begin
        cfg_reg <= cfg_full;
      end
    end
  end

  // Conversion takes the configuration in force at its start
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_conv_reg <= CFG_RST;
    end else if (start_conv) begin
      cfg_conv_reg <= cfg_reg;
    end
  end

  // Acquisition window and its elapsed time
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acq_reg <= 1'b0;
      acq_cnt_reg <= 8'h00;
      acq_ok_reg <= 1'b0;
    end else if (start_conv) begin
      acq_reg <= 1'b0;
      acq_ok_reg <= acq_reg & acq_met;
    end else if (acq_open) begin
      acq_reg <= 1'b1;
      acq_cnt_reg <= 8'h00;
    end else if (acq_reg & ~acq_met) begin
      acq_cnt_reg <= acq_cnt_reg + 8'h01;
    end
  end

  // Output shift register: loaded at conversion end, top bit first
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_shift_reg <= '0;
      out_bit_reg <= 1'b0;
    end else if (sar_done) begin
      out_shift_reg <= {padded[RESULT_W-2:0], 1'b0};
      out_bit_reg <= padded[RESULT_W-1];
    end else if (shift_out) begin
      out_bit_reg <= out_shift_reg[RESULT_W-1];
      out_shift_reg <= {out_shift_reg[RESULT_W-2:0], 1'b0};
    end
  end

  // Last result and conversion count for software
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_reg <= '0;
      conv_cnt_reg <= 16'h0000;
    end else if (sar_done) begin
      result_reg <= padded;
      conv_cnt_reg <= conv_cnt_reg + 16'h0001;
    end
  end

  // Bus answer: one wait cycle, then read data and write take effect
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      rdata_reg <= read_mux;
    end
  end

  // Step time register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_reg <= CTRL_STEP_RST;
    end else if (ctrl_wr) begin
      step_reg <= avs_writedata_i[7:0];
    end
  end

  // Bus outputs
  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o = rdata_reg;

  // Pin outputs
  assign serial_out_o = out_bit_reg;
  assign serial_out_oe_o = ~rd_n_s;
  assign busy_n_o = ~sar_busy;
  assign dac_code_o = RESULT_W'(sar_code) << (RESULT_W - RES_BITS);
  assign mux_cfg_o = cfg_conv_reg[CFG_MUX_HI:CFG_MUX_LO];
  assign single_ended_o = cfg_conv_reg[CFG_SINGLE_BIT];
  assign unipolar_select_o = cfg_conv_reg[CFG_UNIPOLAR_BIT];
  assign gain_o = cfg_conv_reg[CFG_GAIN_BIT];
  assign nap_o = cfg_reg[CFG_NAP_BIT];
  assign sleep_o = cfg_reg[CFG_SLEEP_BIT];
  assign acquire_o = acq_reg;
endmodule // msc_top
`default_nettype wire

/* File: common/msc_pkg.sv */
/*
  Shared constants for the multiplexed converter serial control block:
  register offsets, reset values, configuration word fields and timing.
  Assumes a 40 MHz system clock and a 32-bit Avalon-MM register slave.
*/
package msc_pkg;
  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // Widest result delivered on the serial output
  localparam int unsigned RESULT_W = 16;
  // Configuration word length in serial clock edges
  localparam int unsigned CFG_W = 8;
  // Falling edge after this bit opens acquisition
  localparam logic [3:0] ACQ_OPEN_BIT = 4'h6;
  // Least settling time before a conversion start, in ns
  localparam int unsigned ACQ_MIN_NS = 4000;
  // Same time in clock cycles, rounded up
  localparam int unsigned ACQ_MIN_CYC = (ACQ_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Register byte offsets
  localparam logic [3:0] REG_STATUS_OFS = 4'h0;
  localparam logic [3:0] REG_RESULT_OFS = 4'h4;
  localparam logic [3:0] REG_CTRL_OFS = 4'h8;
  // Control register reset value: cycles per bit decision
  localparam logic [7:0] CTRL_STEP_RST = 8'h04;
  // Configuration word field positions, first bit shifted in is bit 7
  localparam int unsigned CFG_MUX_HI = 7;
  localparam int unsigned CFG_MUX_LO = 4;
  localparam int unsigned CFG_SINGLE_BIT = 7;
  localparam int unsigned CFG_UNIPOLAR_BIT = 3;
  localparam int unsigned CFG_GAIN_BIT = 2;
  localparam int unsigned CFG_NAP_BIT = 1;
  localparam int unsigned CFG_SLEEP_BIT = 0;
  // Configuration value after reset
  localparam logic [7:0] CFG_RST = 8'h00;
  // Status register field positions
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ACQ_BIT = 1;
  localparam int unsigned STAT_ACQ_OK_BIT = 2;
  localparam int unsigned STAT_CFG_LO = 8;
  localparam int unsigned STAT_CNT_LO = 16;
endpackage

/* File: hdl/msc_sar.sv */
/*
  Successive approximation engine: walks a trial code from the top bit
  down, waiting a programmable number of cycles per bit for the DAC to
  settle, then keeps or drops the bit on the comparator decision.
  Assumes the comparator input is already synchronised to sys_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module msc_sar #(
  parameter int unsigned W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] step_i,
  input wire logic cmp_i,
  output logic [W-1:0] code_o,
  output logic busy_o,
  output logic done_o,
  output logic [W-1:0] result_o
);
  import msc_pkg::*;

  typedef enum logic {SAR_IDLE, SAR_RUN} msc_sar_state_t;

  // One-hot mask for a bit position
  function automatic logic [W-1:0] bit_mask(input logic [4:0] idx);
    bit_mask = {{(W-1){1'b0}}, 1'b1} << idx;
  endfunction

  msc_sar_state_t state_reg; // Engine state
  logic [W-1:0] code_reg; // Trial code to the DAC
  logic [4:0] idx_reg; // Bit under decision
  logic [7:0] wait_reg; // Settling countdown
  logic done_reg; // End of conversion pulse
  logic [W-1:0] result_reg; // Last finished code
  wire logic settled = (wait_reg == 8'h00);
  // Trial with the current bit dropped when the comparator says too high
  wire logic [W-1:0] decided = cmp_i ? code_reg : (code_reg & ~bit_mask(idx_reg));

  // Bit walk, top bit first
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SAR_IDLE;
      code_reg <= '0;
      idx_reg <= 5'h00;
      wait_reg <= 8'h00;
      done_reg <= 1'b0;
      result_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        SAR_IDLE: begin
          if (start_i) begin
            code_reg <= bit_mask(5'(W - 1));
            idx_reg <= 5'(W - 1);
            wait_reg <= step_i;
            state_reg <= SAR_RUN;
          end
        end
        SAR_RUN: begin
          if (!settled) begin
            wait_reg <= wait_reg - 8'h01;
          end else if (idx_reg == 5'h00) begin
            // Last bit decided
            code_reg <= decided;
            result_reg <= decided;
            done_reg <= 1'b1;
            state_reg <= SAR_IDLE;
          end else begin
            // Keep decision, try next lower bit
            code_reg <= decided | bit_mask(idx_reg - 5'h01);
            idx_reg <= idx_reg - 5'h01;
            wait_reg <= step_i;
          end
        end
        default: begin
          state_reg <= SAR_IDLE;
        end
      endcase
    end
  end

  assign code_o = code_reg;
  assign busy_o = (state_reg == SAR_RUN);
  assign done_o = done_reg;
  assign result_o = result_reg;
endmodule // msc_sar
`default_nettype wire

/* File: test/msc_host_model.sv */
/*
  Host side of the serial link: full-duplex frames and conversion starts.
  Assumes the bench calls its tasks right after a rising sys_clk_i edge.
*/
`timescale 1ns/10ps
`default_nettype none
module msc_host_model (
  input wire logic sys_clk_i,
  input wire logic serial_out_i,
  output logic sclk_o,
  output logic serial_in_o,
  output logic rd_n_o,
  output logic convert_start_o
);
  // Link idle: clock parked low, read enable off
  initial begin
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
    rd_n_o = 1'b1;
    convert_start_o = 1'b0;
  end
  // One frame: 8 config bits out, 16 result bits back, 200 ns clock
  task automatic xfer(input logic [7:0] cfg, input logic rd_n, output logic [15:0] rx);
    rd_n_o <= rd_n;
    repeat (4) @(posedge sys_clk_i);
    for (int i = 0; i < 16; i++) begin
      serial_in_o <= (i < 8) ? cfg[7-i] : ~serial_in_o;
      repeat (4) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rx[15-i] = serial_out_i;
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    rd_n_o <= 1'b1;
  endtask
  // Settle wait, then a start pulse well over 40 ns
  task automatic start(input int settle);
    repeat (settle) @(posedge sys_clk_i);
    convert_start_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    convert_start_o <= 1'b0;
  endtask
endmodule // msc_host_model
`default_nettype wire

/* File: test/msc_checker_assertions.sv */
/*
  Port assertions for the converter control block.
  Assumes a single sys_clk_i domain and the default 16-bit variant.
*/
`timescale 1ns/10ps
`default_nettype none
module msc_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic rd_n_i,
  input wire logic convert_start_i,
  input wire logic serial_out_oe_o,
  input wire logic busy_n_o,
  input wire logic [msc_pkg::RESULT_W-1:0] dac_code_o,
  input wire logic [3:0] mux_cfg_o,
  input wire logic unipolar_select_o,
  input wire logic gain_o,
  input wire logic acquire_o
);
  import msc_pkg::*;
  logic [7:0] low_cnt; // Cycles spent converting
  // Count busy cycles, saturating
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt <= 8'h00;
    else if (busy_n_o) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start; $rose(convert_start_i) && busy_n_o; endsequence
  sequence s_conv2; !busy_n_o ##1 !busy_n_o; endsequence
  property p_oe_off; rd_n_i [*3] |-> !serial_out_oe_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
  property p_oe_on; (!rd_n_i) [*5] |-> serial_out_oe_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven");
  property p_start; s_start |-> ##[1:6] !busy_n_o; endproperty
  a_start: assert property (p_start) else $error("start edge missed");
  property p_acq_end; s_start |-> ##[1:8] !acquire_o; endproperty
  a_acq_end: assert property (p_acq_end) else $error("acquire still open");
  // A start edge while busy must not reload the running configuration
  property p_no_restart;
    !busy_n_o && $rose(convert_start_i) |-> ##1 $stable(mux_cfg_o) [*3];
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");
  property p_first_trial; $fell(busy_n_o) |-> ##[0:8] dac_code_o == 16'h8000; endproperty
  a_first_trial: assert property (p_first_trial) else $error("top bit not tried first");
  property p_busy_len; $rose(busy_n_o) |-> low_cnt >= 8'h10; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too short");
  property p_cfg_hold; s_conv2 |-> $stable({mux_cfg_o, unipolar_select_o, gain_o}); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("range moved in conversion");
endmodule // msc_checker
bind msc_top msc_checker u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rd_n_i(rd_n_i),
  .convert_start_i(convert_start_i), .serial_out_oe_o(serial_out_oe_o), .busy_n_o(busy_n_o),
  .dac_code_o(dac_code_o), .mux_cfg_o(mux_cfg_o), .unipolar_select_o(unipolar_select_o),
  .gain_o(gain_o), .acquire_o(acquire_o));
`default_nettype wire

/* File: test/tb_top.sv */
/*
  Self-checking bench: register bus, serial frames and conversions.
  Assumes the comparator is an ideal compare against a bench input value.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import msc_pkg::*;
  logic clk, rst_n, av_rd, av_wr, wreq, sclk, ser_in, rd_n, cstart, cmp, ser_out, oe, busy_n;
  logic single, unipol, gain, nap, sleep, acq;
  logic [3:0] av_addr, mux;
  logic [31:0] av_wdata, av_rdata, q;
  logic [15:0] dac, vin, rx;
  int n_mismatch = 0;
  int n_tests = 0;
  // Ideal comparator: keep bit while input not below trial
  assign cmp = (vin >= dac);
  // Released data line shows the inverse of the last bit to the host
  wire logic line_out = oe ? ser_out : ~ser_out;
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  msc_top dut (.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(av_addr), .avs_read_i(av_rd),
    .avs_write_i(av_wr), .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
    .avs_waitrequest_o(wreq), .sclk_i(sclk), .serial_in_i(ser_in), .rd_n_i(rd_n),
    .convert_start_i(cstart), .cmp_i(cmp), .serial_out_o(ser_out), .serial_out_oe_o(oe),
    .busy_n_o(busy_n), .dac_code_o(dac), .mux_cfg_o(mux), .single_ended_o(single),
    .unipolar_select_o(unipol), .gain_o(gain), .nap_o(nap), .sleep_o(sleep), .acquire_o(acq));
  msc_host_model host (.sys_clk_i(clk), .serial_out_i(line_out), .sclk_o(sclk),
    .serial_in_o(ser_in), .rd_n_o(rd_n), .convert_start_o(cstart));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= !wr;
    do @(posedge clk); while (wreq !== 1'b0);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Conversion with a second start pulse thrown in while busy
  task automatic conv(input logic [15:0] v);
    vin <= v;
    host.start(170);
    while (busy_n !== 1'b0) @(posedge clk);
    host.start(2);
    while (busy_n !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  // Counts, verdict, end of run
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    av_addr = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h0;
    vin = 16'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    av(1'b0, REG_CTRL_OFS, 32'h0);
    chk(q, {24'h0, CTRL_STEP_RST});
    av(1'b1, REG_CTRL_OFS, 32'h0000_0006);
    av(1'b0, REG_CTRL_OFS, 32'h0);
    chk(q, 32'h0000_0006);
    av(1'b1, 4'hC, 32'hFFFF_FFFF);
    av(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    host.xfer(8'h9C, 1'b0, rx);
    conv(16'hA5C3);
    chk({25'h0, single, mux, unipol, gain}, 32'h0000_0067);
    av(1'b0, REG_RESULT_OFS, 32'h0);
    chk(q, 32'h0000_A5C3);
    // Status: one conversion, word 9C, settling met; status writes ignored
    av(1'b1, REG_STATUS_OFS, 32'hFFFF_FFFF);
    av(1'b0, REG_STATUS_OFS, 32'h0);
    chk(q, 32'h0001_9C04);
    host.xfer(8'h50, 1'b0, rx);
    chk({16'h0, rx}, 32'h0000_A5C3);
    conv(16'h1234);
    chk({25'h0, single, mux, unipol, gain}, 32'h0000_0014);
    av(1'b0, REG_RESULT_OFS, 32'h0);
    chk(q, 32'h0000_9234);
    host.xfer(8'hFC, 1'b1, rx);
    chk({31'h0, oe}, 32'h0);
    conv(16'h0F0F);
    chk({25'h0, single, mux, unipol, gain}, 32'h0000_0014);
    // Status: three conversions, word still 50, no acquisition window opened
    av(1'b0, REG_STATUS_OFS, 32'h0);
    chk(q, 32'h0003_5000);
    host.xfer(8'h9E, 1'b0, rx);
    chk({16'h0, rx}, 32'h0000_8F0F);
    chk({30'h0, nap, sleep}, 32'h0000_0002);
    results;
  end
endmodule // tb_top
`default_nettype wire
